//--- bench/acrb_adc_control_register_bank_bench.sv
// Self-checking bench for the converter control register bank.
`timescale 1ns/1ps
`include "acrb_consts.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch %0t check %0d", $time, compares); end end
module acrb_adc_control_register_bank_bench;
    localparam [4:0] DEV_ID = 5'h07; // Arbitrary identity value.
    localparam [2:0] SIL_REV = 3'h5; // Arbitrary revision value.
    reg mclk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, frame_tick_i = 0;
    reg [7:0] paddr_i = 8'h00;
    reg [31:0] pwdata_i = 32'h0;
    reg [1:0] detected_speed_i = 2'h2, zero_cross_i = 2'h0;
    reg [23:0] raw_a_i = 24'h000100, raw_b_i = 24'h000040;
    reg [23:0] proc_a_i = 24'h000123, proc_b_i = 24'h000456;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, global_power_down_o, bias_power_down_o, master_clock_halve_o;
    wire master_mode_o, clocks_float_o, serial_data_float_o, serial_format_select_o;
    wire bias_pin_select_o;
    wire [1:0] converter_channel_power_down_o, gain_amp_power_down_o, channel_mute_o;
    wire [1:0] preamp_power_down_o, speed_mode_o, bias_level_select_o, preamp_gain_select_o;
    wire [1:0] highpass_on_o, highpass_hold_o, level_control_on_o;
    wire [23:0] serial_data_a_o, serial_data_b_o;
    wire [9:0] gain_amp_volume_o;
    wire [19:0] digital_attenuation_o;
    int n_errors = 0, compares = 0;
    reg [7:0] q;
    reg e;
    always #12.5 mclk_i = ~mclk_i;
    acrb_adc_control_register_bank #(.DEV_ID(DEV_ID), .SIL_REV(SIL_REV))
    u_acrb_adc_control_register_bank (.mclk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .detected_speed_i, .frame_tick_i,
        .zero_cross_i, .raw_a_i, .raw_b_i, .proc_a_i, .proc_b_i, .serial_data_a_o,
        .serial_data_b_o, .global_power_down_o, .converter_channel_power_down_o,
        .gain_amp_power_down_o, .channel_mute_o, .preamp_power_down_o, .bias_power_down_o,
        .speed_mode_o, .master_clock_halve_o, .master_mode_o, .clocks_float_o,
        .serial_data_float_o, .serial_format_select_o, .bias_pin_select_o, .bias_level_select_o,
        .preamp_gain_select_o, .highpass_on_o, .highpass_hold_o, .level_control_on_o,
        .gain_amp_volume_o, .digital_attenuation_o);
    task automatic apb(input bit w, input [5:0] i, input [7:0] d);
        int n;
        @(posedge mclk_i);
        psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= {i, 2'b00}; pwdata_i <= {24'h0, d};
        @(posedge mclk_i);
        penable_i <= 1;
        n = 0;
        do begin @(posedge mclk_i); n++; end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin n_errors++; $display("mismatch %0t no ready", $time); wrap_up(); end
        q = prdata_o[7:0];
        e = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task wr(input [5:0] i, input [7:0] d); apb(1, i, d); repeat (3) @(posedge mclk_i); endtask
    task rd(input [5:0] i, input [7:0] x); apb(0, i, 8'h00); `CHK(q, x) endtask
    task s_reset_values;
        rd(`ACRB_IDX_IDENT, {DEV_ID, SIL_REV});
        rd(`ACRB_IDX_MICSPD, 8'hAE);
        rd(`ACRB_IDX_ADCCTL, 8'hA0);
        `CHK(preamp_power_down_o, 2'b11)
        `CHK(highpass_on_o, 2'b11)
    endtask
    task s_access;
        reg [7:0] v [2:6];
        v = '{8'h60, 8'h2C, 8'h44, 8'hA5, 8'h5A};
        for (int i = 2; i < 7; i++) begin wr(i, v[i]); rd(i, v[i]); end
        wr(`ACRB_IDX_IDENT, 8'hFF);
        rd(`ACRB_IDX_IDENT, {DEV_ID, SIL_REV});
        rd(6'h07, 8'h00);
        `CHK(e, 1'b1)
    endtask
    task s_speed;
        wr(`ACRB_IDX_INTF, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(`ACRB_IDX_MICSPD, {1'b0, s[1:0], 5'h01});
            `CHK(speed_mode_o, s[1:0])
            `CHK(master_clock_halve_o, 1'b0)
        end
        wr(`ACRB_IDX_MICSPD, 8'h81);
        `CHK(speed_mode_o, 2'h2)
        `CHK(master_clock_halve_o, 1'b1)
        wr(`ACRB_IDX_INTF, 8'h40);
        wr(`ACRB_IDX_MICSPD, 8'h11);
        `CHK(master_clock_halve_o, 1'b1)
        `CHK({master_mode_o, clocks_float_o, serial_data_float_o}, 3'b111)
        wr(`ACRB_IDX_INTF, 8'h04);
        `CHK({master_mode_o, clocks_float_o, serial_data_float_o}, 3'b001)
        `CHK(serial_format_select_o, 1'b1)
        wr(`ACRB_IDX_INTF, 8'h00);
        `CHK(serial_format_select_o, 1'b0)
    endtask
    task s_mic;
        for (int k = 0; k < 4; k++) begin
            wr(`ACRB_IDX_MIC, {3'b000, k[0], k[1:0], ~k[1:0]});
            `CHK(bias_pin_select_o, k[0])
            `CHK(bias_level_select_o, k[1:0])
            `CHK(preamp_gain_select_o, ~k[1:0])
        end
        wr(`ACRB_IDX_MICSPD, 8'hA0);
        `CHK({preamp_power_down_o, bias_power_down_o}, 3'b000)
        wr(`ACRB_IDX_ADCCTL, 8'h50);
        `CHK({highpass_on_o, highpass_hold_o}, 4'b0011)
        wr(`ACRB_IDX_PGA_A, 8'h0C);
        wr(`ACRB_IDX_PGA_B, 8'h03);
        wr(`ACRB_IDX_ATT_A, 8'h10);
        wr(`ACRB_IDX_ENGINE, 8'h01);
        wr(`ACRB_IDX_MIC, 8'h80);
        `CHK(gain_amp_volume_o, {5'h0C, 5'h0C})
        `CHK({level_control_on_o, digital_attenuation_o}, {2'b11, {2{10'h040}}})
    endtask
    task s_power;
        wr(`ACRB_IDX_POWER, 8'h62);
        `CHK(channel_mute_o, 2'b01)
        `CHK(converter_channel_power_down_o, 2'b00)
        wr(`ACRB_IDX_POWER, 8'h61);
        `CHK({global_power_down_o, converter_channel_power_down_o}, 3'b111)
        rd(`ACRB_IDX_MIC, 8'h80);
        wr(`ACRB_IDX_POWER, 8'h63);
        wr(`ACRB_IDX_POWER, 8'h62);
        `CHK({converter_channel_power_down_o, channel_mute_o}, 4'b0101)
        wr(`ACRB_IDX_POWER, 8'h60);
        `CHK(channel_mute_o, 2'b00)
    endtask
    task s_mix;
        wr(`ACRB_IDX_MIC, 8'h00);
        `CHK({serial_data_a_o, serial_data_b_o}, {raw_a_i, raw_b_i})
        wr(`ACRB_IDX_INTF, 8'h02);
        `CHK(serial_data_a_o, 24'h000000)
        wr(`ACRB_IDX_ENGINE, 8'h40);
        `CHK({serial_data_a_o, serial_data_b_o}, {proc_a_i, proc_b_i})
        wr(`ACRB_IDX_INTF, 8'h01);
        `CHK({serial_data_a_o, serial_data_b_o}, {2{24'h000060}})
        wr(`ACRB_IDX_INTF, 8'h00);
        wr(`ACRB_IDX_MIC, 8'h20);
        `CHK({serial_data_a_o, serial_data_b_o}, {24'h000A00, raw_b_i})
    endtask
    task wrap_up;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk_i);
        rst_b_i <= 1;
        s_reset_values();
        s_access();
        s_speed();
        s_mic();
        s_power();
        s_mix();
        wrap_up();
    end
endmodule // acrb_adc_control_register_bank_bench

//--- bench/acrb_monitor.sv
// Assertion checker for the converter control register bank.
`timescale 1ns/1ps
`include "acrb_consts.vh"
module acrb_monitor #(
    parameter [4:0] DEV_ID = 5'h05,
    parameter [2:0] SIL_REV = 3'h2
) (
    input wire mclk_i,
    input wire rst_b_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire [1:0] detected_speed_i,
    input wire global_power_down_o,
    input wire [1:0] converter_channel_power_down_o,
    input wire [1:0] gain_amp_power_down_o,
    input wire [1:0] preamp_power_down_o,
    input wire bias_power_down_o,
    input wire [1:0] speed_mode_o,
    input wire master_clock_halve_o,
    input wire master_mode_o,
    input wire clocks_float_o,
    input wire serial_data_float_o,
    input wire serial_format_select_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    wire [5:0] idx = paddr_i[7:2];
    wire wr = psel_i & penable_i & pwrite_i & pready_o;
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_ready; psel_i && !penable_i |=> pready_o ##1 !pready_o; endproperty
    a_ready: assert property (p_ready) else $error("ready not one access cycle");
    property p_ident; pready_o && !pwrite_i && idx == `ACRB_IDX_IDENT |->
        prdata_o == {24'h0, DEV_ID, SIL_REV}; endproperty
    a_ident: assert property (p_ident) else $error("identity read wrong");
    property p_pdn; $rose(global_power_down_o) |-> ##[0:2]
        (converter_channel_power_down_o == 2'b11 && gain_amp_power_down_o == 2'b11); endproperty
    a_pdn: assert property (p_pdn) else $error("global power-down not applied");
    property p_master; wr && idx == `ACRB_IDX_INTF |-> ##2 master_mode_o == $past(pwdata_i[6], 2);
    endproperty
    a_master: assert property (p_master) else $error("master select wrong");
    property p_format; wr && idx == `ACRB_IDX_INTF |=> ##1
        serial_format_select_o == $past(pwdata_i[2], 2); endproperty
    a_format: assert property (p_format) else $error("format select wrong");
    property p_speed; wr && idx == `ACRB_IDX_MICSPD && !pwdata_i[7] |-> ##2
        speed_mode_o == $past(pwdata_i[6:5], 2); endproperty
    a_speed: assert property (p_speed) else $error("speed field not applied");
    property p_auto; wr && idx == `ACRB_IDX_MICSPD && pwdata_i[7] && !master_mode_o |-> ##2
        speed_mode_o == detected_speed_i; endproperty
    a_auto: assert property (p_auto) else $error("detected speed not applied");
    property p_halve; wr && idx == `ACRB_IDX_MICSPD && !pwdata_i[7] && !master_mode_o |-> ##2
        !master_clock_halve_o; endproperty
    a_halve: assert property (p_halve) else $error("halve not ignored");
    property p_float; clocks_float_o |-> master_mode_o && serial_data_float_o; endproperty
    a_float: assert property (p_float) else $error("clock float in slave");
    property p_reset; $rose(rst_b_i) |-> preamp_power_down_o == 2'b11 && bias_power_down_o;
    endproperty
    a_reset: assert property (p_reset) else $error("mic power-down reset wrong");
    c_intf: cover property (wr && idx == `ACRB_IDX_INTF);
    c_float: cover property (clocks_float_o);
    c_pdn: cover property ($rose(global_power_down_o));
endmodule // acrb_monitor
bind acrb_adc_control_register_bank acrb_monitor #(.DEV_ID(DEV_ID), .SIL_REV(SIL_REV)) u_mon (.*);

//--- logic/acrb_adc_control_register_bank.v
// Control register bank of the stereo converter with its APB slave.
`timescale 1ns/1ps
`include "acrb_consts.vh"
module acrb_adc_control_register_bank #(
    parameter DW = 24,
    // Identity values are arbitrary.
    parameter [4:0] DEV_ID = 5'h05,
    parameter [2:0] SIL_REV = 3'h2
) (
    input wire mclk_i,
    input wire rst_b_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire [1:0] detected_speed_i,
    input wire frame_tick_i,
    input wire [1:0] zero_cross_i,
    input wire [DW-1:0] raw_a_i,
    input wire [DW-1:0] raw_b_i,
    input wire [DW-1:0] proc_a_i,
    input wire [DW-1:0] proc_b_i,
    output wire [DW-1:0] serial_data_a_o,
    output wire [DW-1:0] serial_data_b_o,
    output reg global_power_down_o,
    output reg [1:0] converter_channel_power_down_o,
    output reg [1:0] gain_amp_power_down_o,
    output reg [1:0] channel_mute_o,
    output reg [1:0] preamp_power_down_o,
    output reg bias_power_down_o,
    output reg [1:0] speed_mode_o,
    output reg master_clock_halve_o,
    output reg master_mode_o,
    output reg clocks_float_o,
    output reg serial_data_float_o,
    output reg serial_format_select_o,
    output reg bias_pin_select_o,
    output reg [1:0] bias_level_select_o,
    output reg [1:0] preamp_gain_select_o,
    output reg [1:0] highpass_on_o,
    output reg [1:0] highpass_hold_o,
    output reg [1:0] level_control_on_o,
    output wire [9:0] gain_amp_volume_o,
    output wire [19:0] digital_attenuation_o
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    reg [7:0] power_reg;
    reg [7:0] micspd_reg;
    reg [7:0] intf_reg;
    reg [7:0] mic_reg;
    reg [7:0] adcctl_reg;
    reg [7:0] engine_reg;
    reg [4:0] pga_a_reg;
    reg [4:0] pga_b_reg;
    reg [7:0] att_a_reg;
    reg [7:0] att_b_reg;
    reg up_reg;
    reg [1:0] adc_off_reg;
    reg [1:0] pga_off_reg;
    reg [7:0] rd_data;
    reg rd_hit;
    wire [5:0] idx = paddr_i[7:2];
    wire wr_en = psel_i & penable_i & pwrite_i & pready_o;
    wire [7:0] wbyte = pwdata_i[7:0];
    wire slave = ~intf_reg[`ACRB_IF_MASTER];
    wire linked = mic_reg[`ACRB_MIC_LINK];
    wire global_pdn = power_reg[`ACRB_PWR_GLOBAL];
    wire [1:0] adc_bits = power_reg[`ACRB_PWR_ADC_A+1:`ACRB_PWR_ADC_A];
    wire [1:0] pga_bits = power_reg[`ACRB_PWR_PGA_A+1:`ACRB_PWR_PGA_A];
    wire [1:0] ch_pdn = adc_bits | pga_bits;
    wire route_reserved = intf_reg[`ACRB_IF_ROUTE] & ~engine_reg[`ACRB_EN_ENGINE];

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always @* begin
        rd_data = 8'h00;
        rd_hit = 1'b1;
        case (idx)
            `ACRB_IDX_IDENT: rd_data = {DEV_ID, SIL_REV};
            `ACRB_IDX_POWER: rd_data = power_reg;
            `ACRB_IDX_MICSPD: rd_data = micspd_reg;
            `ACRB_IDX_INTF: rd_data = intf_reg;
            `ACRB_IDX_MIC: rd_data = mic_reg;
            `ACRB_IDX_ADCCTL: rd_data = adcctl_reg;
            `ACRB_IDX_ENGINE: rd_data = engine_reg;
            `ACRB_IDX_PGA_A: rd_data = {3'h0, pga_a_reg};
            `ACRB_IDX_PGA_B: rd_data = {3'h0, pga_b_reg};
            `ACRB_IDX_ATT_A: rd_data = att_a_reg;
            `ACRB_IDX_ATT_B: rd_data = att_b_reg;
            `ACRB_IDX_STATUS: rd_data = {2'h0, route_reserved, up_reg, master_clock_halve_o,
                                         speed_mode_o, global_power_down_o};
            default: rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // APB slave: one access cycle, ready registered from the setup cycle
    // ----------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~penable_i;
            if (psel_i && !penable_i) begin
                prdata_o <= pwrite_i ? 32'h00000000 : {24'h000000, rd_data};
                pslverr_o <= ~rd_hit;
            end else if (pready_o) begin
                prdata_o <= 32'h00000000;
                pslverr_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Identity and status take no write and answer without error.
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_reg <= `ACRB_RST_POWER;
            micspd_reg <= `ACRB_RST_MICSPD;
            intf_reg <= `ACRB_RST_INTF;
            mic_reg <= `ACRB_RST_MIC;
            adcctl_reg <= `ACRB_RST_ADCCTL;
            engine_reg <= `ACRB_RST_ENGINE;
            pga_a_reg <= `ACRB_RST_PGA;
            pga_b_reg <= `ACRB_RST_PGA;
            att_a_reg <= `ACRB_RST_ATT;
            att_b_reg <= `ACRB_RST_ATT;
        end else if (wr_en) begin
            case (idx)
                `ACRB_IDX_POWER: power_reg <= wbyte;
                `ACRB_IDX_MICSPD: micspd_reg <= wbyte;
                `ACRB_IDX_INTF: intf_reg <= wbyte;
                `ACRB_IDX_MIC: mic_reg <= wbyte;
                `ACRB_IDX_ADCCTL: adcctl_reg <= wbyte;
                `ACRB_IDX_ENGINE: engine_reg <= wbyte;
                `ACRB_IDX_PGA_A: pga_a_reg <= wbyte[4:0];
                `ACRB_IDX_PGA_B: pga_b_reg <= wbyte[4:0];
                `ACRB_IDX_ATT_A: att_a_reg <= wbyte;
                `ACRB_IDX_ATT_B: att_b_reg <= wbyte;
                default: power_reg <= power_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power sequencing
    // ----------------------------------------------------------------
    // The converter counts as up once global power-down is clear and a
    // channel is on. While up, channel bits are latched off only by a
    // return through the down state, so a single channel bit just mutes.
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            up_reg <= 1'b0;
            adc_off_reg <= 2'b00;
            pga_off_reg <= 2'b00;
            channel_mute_o <= 2'b00;
            global_power_down_o <= 1'b0;
        end else begin
            up_reg <= ~global_pdn & ~(ch_pdn[0] & ch_pdn[1]);
            global_power_down_o <= global_pdn;
            if (!up_reg) begin
                adc_off_reg <= adc_bits;
                pga_off_reg <= pga_bits;
            end
            channel_mute_o <= up_reg ? ch_pdn : 2'b00;
        end
    end

    // ----------------------------------------------------------------
    // Effective controls
    // ----------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            converter_channel_power_down_o <= 2'b00;
            gain_amp_power_down_o <= 2'b00;
            preamp_power_down_o <= 2'b11;
            bias_power_down_o <= 1'b1;
            speed_mode_o <= 2'b01;
            master_clock_halve_o <= 1'b0;
            master_mode_o <= 1'b0;
            clocks_float_o <= 1'b0;
            serial_data_float_o <= 1'b0;
            serial_format_select_o <= 1'b0;
            bias_pin_select_o <= 1'b0;
            bias_level_select_o <= 2'b00;
            preamp_gain_select_o <= 2'b00;
            highpass_on_o <= 2'b11;
            highpass_hold_o <= 2'b00;
            level_control_on_o <= 2'b00;
        end else begin
            converter_channel_power_down_o <= adc_off_reg | {2{global_pdn}};
            gain_amp_power_down_o <= pga_off_reg | {2{global_pdn}};
            preamp_power_down_o <= micspd_reg[`ACRB_MS_PRE_A+1:`ACRB_MS_PRE_A];
            bias_power_down_o <= micspd_reg[`ACRB_MS_BIAS_PDN];
            if (micspd_reg[`ACRB_MS_AUTO] && slave) begin
                speed_mode_o <= detected_speed_i;
            end else begin
                speed_mode_o <= micspd_reg[`ACRB_MS_SPEED_LO+1:`ACRB_MS_SPEED_LO];
            end
            master_clock_halve_o <= micspd_reg[`ACRB_MS_HALVE] &
                                    ~(slave & ~micspd_reg[`ACRB_MS_AUTO]);
            master_mode_o <= ~slave;
            clocks_float_o <= micspd_reg[`ACRB_MS_FLOAT] & ~slave;
            serial_data_float_o <= micspd_reg[`ACRB_MS_FLOAT];
            serial_format_select_o <= intf_reg[`ACRB_IF_FORMAT];
            bias_pin_select_o <= mic_reg[`ACRB_MIC_PIN];
            bias_level_select_o <= mic_reg[`ACRB_MIC_LVL_LO+1:`ACRB_MIC_LVL_LO];
            preamp_gain_select_o <= mic_reg[`ACRB_MIC_GAIN_A+1:`ACRB_MIC_GAIN_A];
            highpass_on_o <= {adcctl_reg[7], adcctl_reg[5]};
            highpass_hold_o <= {adcctl_reg[6], adcctl_reg[4]};
            level_control_on_o[0] <= engine_reg[`ACRB_EN_LEVEL_A];
            level_control_on_o[1] <= linked ? engine_reg[`ACRB_EN_LEVEL_A] :
                                     engine_reg[`ACRB_EN_LEVEL_A+1];
        end
    end

    // ----------------------------------------------------------------
    // Per-channel gain and attenuation ramps
    // ----------------------------------------------------------------
    wire [9:0] pga_tgt = {linked ? pga_a_reg : pga_b_reg, pga_a_reg};
    wire [7:0] att_b_sel = linked ? att_a_reg : att_b_reg;
    wire [19:0] att_tgt = {att_b_sel, {`ACRB_ATT_FRAC{1'b0}},
                           att_a_reg, {`ACRB_ATT_FRAC{1'b0}}};
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            acrb_level_stepper #(
                .W(5),
                .INTERVAL(`ACRB_GAIN_INTERVAL),
                .TIMEOUT(`ACRB_CROSS_TIMEOUT)
            ) u_gain (
                .mclk_i(mclk_i),
                .rst_b_i(rst_b_i),
                .target_i(pga_tgt[5*ch+4:5*ch]),
                .ramp_on_i(adcctl_reg[2*ch+1]),
                .wait_on_i(adcctl_reg[2*ch]),
                .frame_tick_i(frame_tick_i),
                .zero_cross_i(zero_cross_i[ch]),
                .level_o(gain_amp_volume_o[5*ch+4:5*ch])
            );
            acrb_level_stepper #(
                .W(10),
                .INTERVAL(`ACRB_ATT_INTERVAL),
                .TIMEOUT(`ACRB_CROSS_TIMEOUT)
            ) u_att (
                .mclk_i(mclk_i),
                .rst_b_i(rst_b_i),
                .target_i(att_tgt[10*ch+9:10*ch]),
                .ramp_on_i(adcctl_reg[2*ch+1]),
                .wait_on_i(1'b0),
                .frame_tick_i(frame_tick_i),
                .zero_cross_i(zero_cross_i[ch]),
                .level_o(digital_attenuation_o[10*ch+9:10*ch])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Sample path
    // ----------------------------------------------------------------
    acrb_sample_mixer #(
        .DW(DW)
    ) u_mix (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .raw_a_i(raw_a_i),
        .raw_b_i(raw_b_i),
        .proc_a_i(proc_a_i),
        .proc_b_i(proc_b_i),
        .route_i(intf_reg[`ACRB_IF_ROUTE]),
        .engine_on_i(engine_reg[`ACRB_EN_ENGINE]),
        .diff_mix_i(intf_reg[`ACRB_IF_DIFF]),
        .boost_i(mic_reg[`ACRB_MIC_BOOST_A+1:`ACRB_MIC_BOOST_A]),
        .mute_i(channel_mute_o),
        .out_a_o(serial_data_a_o),
        .out_b_o(serial_data_b_o)
    );
endmodule // acrb_adc_control_register_bank

//--- logic/acrb_consts.vh
// Constants for the converter control register bank.
// Function
// - All registers read and write, except identity and status, which are read-only.
// - Identity register returns device identifier in 7:3 and revision in 2:0.
// - Channel power-down after full power-up, other channel on, only mutes.
// - Global power-down enters low power and keeps all register contents.
// - Auto-detect in slave operation takes detected speed, ignores speed field.
// - Speed field: 11 quarter, 10 half, 01 single (default), 00 double.
// - Float bit: master floats clocks and data, slave floats data only.
// - Preamp and bias power-down bits reset to 1, powering circuits down.
// - Clock halve applies, except in slave operation with auto-detect off.
// - Master/slave bit: 0 slave (default), 1 master.
// - Format bit: 0 left-justified (default), 1 I2S.
// - Route 0 raw data; route 1 with engine on processed; 1 with 0 reserved.
// - Differential mix outputs (A minus B) divided by two on both channels.
// - Linked volume: channel A volume, attenuation, level control govern both.
// - Digital boost applies fixed 20 dB gain to the channel.
// - Bias pin select: 0 third B input pin, 1 second B input pin.
// - Bias level codes 00..11 give 0.8, 0.7, 0.6, 0.5 of supply.
// - Preamp gain select: 0 gives +16 dB, 1 gives +32 dB.
// - Ramp: attenuation 0.125 dB per frame, gain 0.5 dB per 16 frames.
// - Crossing wait delays gain changes to zero crossing, 1024 sample timeout.
// - High-pass enable bits reset to 1; clearing disables the filter.
`ifndef ACRB_CONSTS_VH
`define ACRB_CONSTS_VH
`define ACRB_IDX_IDENT 6'h01
`define ACRB_IDX_POWER 6'h02
`define ACRB_IDX_MICSPD 6'h03
`define ACRB_IDX_INTF 6'h04
`define ACRB_IDX_MIC 6'h05
`define ACRB_IDX_ADCCTL 6'h06
`define ACRB_IDX_ENGINE 6'h09
`define ACRB_IDX_PGA_A 6'h0A
`define ACRB_IDX_PGA_B 6'h0B
`define ACRB_IDX_ATT_A 6'h0C
`define ACRB_IDX_ATT_B 6'h0D
`define ACRB_IDX_STATUS 6'h0E
`define ACRB_RST_POWER 8'h00
`define ACRB_RST_MICSPD 8'hAE
`define ACRB_RST_INTF 8'h00
`define ACRB_RST_MIC 8'h00
`define ACRB_RST_ADCCTL 8'hA0
`define ACRB_RST_ENGINE 8'h00
`define ACRB_RST_PGA 5'h00
`define ACRB_RST_ATT 8'h00
`define ACRB_PWR_GLOBAL 0
`define ACRB_PWR_ADC_A 1
`define ACRB_PWR_PGA_A 3
`define ACRB_MS_HALVE 0
`define ACRB_MS_BIAS_PDN 1
`define ACRB_MS_PRE_A 2
`define ACRB_MS_FLOAT 4
`define ACRB_MS_SPEED_LO 5
`define ACRB_MS_AUTO 7
`define ACRB_IF_DIFF 0
`define ACRB_IF_ROUTE 1
`define ACRB_IF_FORMAT 2
`define ACRB_IF_MASTER 6
`define ACRB_MIC_GAIN_A 0
`define ACRB_MIC_LVL_LO 2
`define ACRB_MIC_PIN 4
`define ACRB_MIC_BOOST_A 5
`define ACRB_MIC_LINK 7
`define ACRB_EN_LEVEL_A 0
`define ACRB_EN_ENGINE 6
`define ACRB_GAIN_INTERVAL 16
`define ACRB_ATT_INTERVAL 1
`define ACRB_CROSS_TIMEOUT 1024
`define ACRB_ATT_FRAC 2
`endif

//--- logic/acrb_level_stepper.v
// Level stepper that moves a gain or attenuation toward its target.
`timescale 1ns/1ps
`include "acrb_consts.vh"
module acrb_level_stepper #(
    parameter W = 5,
    parameter INTERVAL = 16,
    parameter TIMEOUT = 1024
) (
    input wire mclk_i,
    input wire rst_b_i,
    input wire [W-1:0] target_i,
    input wire ramp_on_i,
    input wire wait_on_i,
    input wire frame_tick_i,
    input wire zero_cross_i,
    output reg [W-1:0] level_o
);
    reg [4:0] frame_cnt_reg;
    reg [10:0] tmo_cnt_reg;
    wire pending = (target_i != level_o);
    wire tmo_hit = (tmo_cnt_reg == TIMEOUT - 1) & frame_tick_i;
    wire gate_ok = ~wait_on_i | zero_cross_i | tmo_hit;
    wire step_due = frame_tick_i & (frame_cnt_reg == INTERVAL - 1);
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_o <= {W{1'b0}};
            frame_cnt_reg <= 5'h00;
            tmo_cnt_reg <= 11'h000;
        end else begin
            if (frame_tick_i) begin
                frame_cnt_reg <= step_due ? 5'h00 : frame_cnt_reg + 5'h01;
            end
            if (!pending || gate_ok) begin
                tmo_cnt_reg <= 11'h000;
            end else if (frame_tick_i) begin
                tmo_cnt_reg <= tmo_cnt_reg + 11'h001;
            end
            if (pending && gate_ok) begin
                if (!ramp_on_i) begin
                    level_o <= target_i;
                end else if (step_due || (wait_on_i && zero_cross_i)) begin
                    level_o <= (target_i > level_o) ? level_o + 1'b1 : level_o - 1'b1;
                end
            end
        end
    end
endmodule // acrb_level_stepper

//--- logic/acrb_sample_mixer.v
// Output sample routing, boost, differential mix and channel mute.
`timescale 1ns/1ps
`include "acrb_consts.vh"
module acrb_sample_mixer #(
    parameter DW = 24
) (
    input wire mclk_i,
    input wire rst_b_i,
    input wire [DW-1:0] raw_a_i,
    input wire [DW-1:0] raw_b_i,
    input wire [DW-1:0] proc_a_i,
    input wire [DW-1:0] proc_b_i,
    input wire route_i,
    input wire engine_on_i,
    input wire diff_mix_i,
    input wire [1:0] boost_i,
    input wire [1:0] mute_i,
    output reg [DW-1:0] out_a_o,
    output reg [DW-1:0] out_b_o
);
    localparam signed [DW+3:0] MAXV = (1 <<< (DW - 1)) - 1;
    localparam signed [DW+3:0] MINV = -(1 <<< (DW - 1));
    function [DW-1:0] boost;
        input [DW-1:0] x;
        input en;
        reg signed [DW+3:0] s;
        begin
            s = {{4{x[DW-1]}}, x};
            s = (s <<< 3) + (s <<< 1);
            if (!en) begin
                boost = x;
            end else if (s > MAXV) begin
                boost = MAXV[DW-1:0];
            end else if (s < MINV) begin
                boost = MINV[DW-1:0];
            end else begin
                boost = s[DW-1:0];
            end
        end
    endfunction
    reg [DW-1:0] sel_a;
    reg [DW-1:0] sel_b;
    reg [DW:0] diff;
    always @* begin
        sel_a = route_i ? proc_a_i : raw_a_i;
        sel_b = route_i ? proc_b_i : raw_b_i;
        if (route_i && !engine_on_i) begin
            sel_a = {DW{1'b0}};
            sel_b = {DW{1'b0}};
        end
        sel_a = boost(sel_a, boost_i[0]);
        sel_b = boost(sel_b, boost_i[1]);
        diff = {sel_a[DW-1], sel_a} - {sel_b[DW-1], sel_b};
        if (diff_mix_i) begin
            sel_a = diff[DW:1];
            sel_b = diff[DW:1];
        end
    end
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_a_o <= {DW{1'b0}};
            out_b_o <= {DW{1'b0}};
        end else begin
            out_a_o <= mute_i[0] ? {DW{1'b0}} : sel_a;
            out_b_o <= mute_i[1] ? {DW{1'b0}} : sel_b;
        end
    end
endmodule // acrb_sample_mixer
